// ==== shared/cht_params.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the cap health test
// Assumes: 8-bit register map, 20 MHz core clock
// Notes:   included by every logic and verif file of the block
`ifndef CHT_PARAMS_SVH
`define CHT_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CHT_OFS_CTRL      8'h01
`define CHT_OFS_STATUS    8'h02
`define CHT_OFS_MASK      8'h04
`define CHT_OFS_THRESH    8'h06
`define CHT_OFS_FINAL_HI  8'h12
`define CHT_OFS_FINAL_LO  8'h13
`define CHT_OFS_INIT_HI   8'h14
`define CHT_OFS_INIT_LO   8'h15
`define CHT_OFS_TIME_LO   8'h16
`define CHT_OFS_TIME_HI   8'h17
`define CHT_OFS_REG_CTRL  8'h1b

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CHT_BIT_BOOST_EN  0
`define CHT_BIT_TEST_REQ  3
`define CHT_BIT_SPG_FAIL  2
`define CHT_BIT_ADC_DONE  6
`define CHT_BIT_TEST_DONE 7
`define CHT_BIT_REG_EN    1
`define CHT_STATUS_USED   8'hc4
`define CHT_RST_CTRL      8'h01
`define CHT_RST_MASK      8'h00
`define CHT_RST_THRESH    8'h00
`define CHT_RST_REG_CTRL  8'h00
`define CHT_HOST_MASK_SET 8'h44
`define CHT_HOST_START    8'h09

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CHT_CLK_NS        50
`define CHT_MS_NS         1000000
`define CHT_MS_CYCLES     (`CHT_MS_NS / `CHT_CLK_NS)

`endif

// ==== shared/cht_pkg.sv ====
// Purpose: types shared by both ends of the cap health test
// Assumes: nothing beyond the params header
// Notes:   constants live in cht_params.svh
package cht_pkg;

  // ---------------------------------------------------------------
  // device sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CHT_IDLE   = 3'b000,
    CHT_CHARGE = 3'b001,
    CHT_DISCH  = 3'b010,
    CHT_ADC1   = 3'b011,
    CHT_TIMING = 3'b100,
    CHT_ADC2   = 3'b101
  } cht_state_t;

  // ---------------------------------------------------------------
  // host sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CHT_H_IDLE = 2'b00,
    CHT_H_RUN  = 2'b01,
    CHT_H_WAIT = 2'b10
  } cht_hstate_t;

  typedef logic [7:0] cht_byte_t;

endpackage : cht_pkg

// ==== shared/cht_if.sv ====
// Purpose: register port and alert line between host and device
// Assumes: one clock, read data one cycle after the read strobe
// Notes:   stands in for the serial host bus
`timescale 1ns/1ns
interface cht_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       alert;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata, output alert);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input alert);
endinterface : cht_if

// ==== logic/cht_ms_tick.sv ====
// Purpose: one-cycle enable every millisecond while running
// Assumes: core clock period as in the params header
// Notes:   restarts from zero whenever run drops
`timescale 1ns/1ns
`include "cht_params.svh"
module cht_ms_tick #(
  parameter int unsigned CYCLES = `CHT_MS_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  // a period below two cycles would never leave the wrap branch
  if (CYCLES < 2) begin : g_bad_cycles
    $error("cht_ms_tick: CYCLES must be at least 2");
  end

  logic [31:0] cnt_q;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
    end else if (!run || cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // first tick lands one full period after run rises
  assign tick = run && (cnt_q == CYCLES - 1);
endmodule : cht_ms_tick

// ==== logic/cht_device.sv ====
// Purpose: cap health test sequencer with its register file
// Assumes: analog status pins asynchronous, converter holds data while done is high
// Notes:   converter, boost and buck power stages stay outside
`timescale 1ns/1ns
`include "cht_params.svh"
module cht_device
  import cht_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CHT_MS_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  cht_if.dev              bus,
  input  wire logic       storage_charged_pin,
  input  wire logic       storage_feedback_at_ref_pin,
  input  wire logic       storage_power_good_pin,
  input  wire logic       input_power_fail_pin,
  input  wire logic       storage_depleted_pin,
  input  wire logic       adc_done_pin,
  input  wire logic [9:0] adc_data,
  output logic            adc_start,
  output logic            boost_switch_en,
  output logic            discharge_switch_on,
  output logic            buck_release,
  output logic            storage_to_core_regulator_enable,
  output logic [7:0]      storage_good_threshold
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = bus.wr && (bus.addr == ofs);
  endfunction : wr_hit

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pin_meta_q;
  logic [5:0] pin_q;
  logic       spg_prev_q;
  logic       adc_prev_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= 6'h00;
      pin_q      <= 6'h00;
    end else begin
      pin_meta_q <= {adc_done_pin, storage_depleted_pin, input_power_fail_pin,
                     storage_power_good_pin, storage_feedback_at_ref_pin, storage_charged_pin};
      pin_q      <= pin_meta_q;
    end
  end

  logic charged;
  logic fb_at_ref;
  logic spg_ok;
  logic pwr_fail;
  logic depleted;
  logic adc_done;
  assign charged   = pin_q[0];
  assign fb_at_ref = pin_q[1];
  assign spg_ok    = pin_q[2];
  assign pwr_fail  = pin_q[3];
  assign depleted  = pin_q[4];
  assign adc_done  = pin_q[5];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      spg_prev_q <= 1'b0;
      adc_prev_q <= 1'b0;
    end else begin
      spg_prev_q <= spg_ok;
      adc_prev_q <= adc_done;
    end
  end

  logic spg_fall;
  logic adc_rise;
  assign spg_fall = spg_prev_q && !spg_ok;
  assign adc_rise = adc_done && !adc_prev_q;

  // ---------------------------------------------------------------
  // buck release mode
  // ---------------------------------------------------------------
  logic buck_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buck_q <= 1'b0;
    end else if (pwr_fail) begin
      buck_q <= 1'b1;
    end else if (depleted) begin
      buck_q <= 1'b0;
    end
  end
  assign buck_release = buck_q;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  cht_state_t state_q;
  logic [7:0] ctrl_q;
  logic       finish;
  logic       accept;
  logic       timing;
  logic       ms_tick;
  logic [15:0] count_q;
  logic [15:0] time_q;
  logic [9:0]  init_q;
  logic [9:0]  final_q;

  assign accept = (state_q == CHT_IDLE) && ctrl_q[`CHT_BIT_TEST_REQ] && !buck_q;
  // an abort in the last conversion must not report a finished test
  assign finish = (state_q == CHT_ADC2) && adc_rise && !buck_q;
  assign timing = (state_q == CHT_ADC1) || (state_q == CHT_TIMING);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CHT_IDLE;
    end else if (buck_q && state_q != CHT_IDLE) begin
      state_q <= CHT_IDLE;
    end else begin
      unique case (state_q)
        CHT_IDLE:   if (accept) state_q <= CHT_CHARGE;
        CHT_CHARGE: if (charged) state_q <= CHT_DISCH;
        CHT_DISCH:  if (fb_at_ref) state_q <= CHT_ADC1;
        CHT_ADC1:   if (adc_rise) state_q <= CHT_TIMING;
        CHT_TIMING: if (!spg_ok) state_q <= CHT_ADC2;
        CHT_ADC2:   if (adc_rise) state_q <= CHT_IDLE;
        default:    state_q <= CHT_IDLE;
      endcase
    end
  end

  // conversion launched on entry to either conversion state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= !buck_q && (((state_q == CHT_DISCH) && fb_at_ref)
                            || ((state_q == CHT_TIMING) && !spg_ok));
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      init_q  <= 10'h000;
      final_q <= 10'h000;
    end else if (adc_rise && state_q == CHT_ADC1) begin
      init_q  <= adc_data;
    end else if (finish) begin
      final_q <= adc_data;
    end
  end

  cht_ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .rstn     (rstn),
    .run      (timing),
    .tick     (ms_tick)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else if (accept) begin
      count_q <= 16'h0000;
    end else if (timing && ms_tick && count_q != 16'hffff) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      time_q <= 16'h0000;
    end else if (state_q == CHT_TIMING && !spg_ok) begin
      time_q <= count_q;
    end
  end

  // power stage controls; boost bit itself is never altered by the test
  assign boost_switch_en     = ctrl_q[`CHT_BIT_BOOST_EN] && !buck_q
                               && !(state_q inside {CHT_DISCH, CHT_ADC1, CHT_TIMING, CHT_ADC2})
                               && !(state_q == CHT_CHARGE && charged);
  // buck mode opens the switch at once, before the state has left the test
  assign discharge_switch_on = !buck_q
                               && (state_q inside {CHT_DISCH, CHT_ADC1, CHT_TIMING});

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [7:0] thresh_q;
  logic [7:0] regc_q;
  logic [7:0] status_set;
  logic [7:0] status_clr;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `CHT_RST_CTRL;
    end else if (wr_hit(`CHT_OFS_CTRL)) begin
      ctrl_q <= bus.wdata;
    end else if (finish || (buck_q && state_q != CHT_IDLE)) begin
      ctrl_q[`CHT_BIT_TEST_REQ] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q   <= `CHT_RST_MASK;
      thresh_q <= `CHT_RST_THRESH;
      regc_q   <= `CHT_RST_REG_CTRL;
    end else begin
      if (wr_hit(`CHT_OFS_MASK)) mask_q <= bus.wdata;
      if (wr_hit(`CHT_OFS_THRESH)) thresh_q <= bus.wdata;
      if (wr_hit(`CHT_OFS_REG_CTRL)) regc_q <= bus.wdata;
    end
  end
  assign storage_good_threshold           = thresh_q;
  assign storage_to_core_regulator_enable = regc_q[`CHT_BIT_REG_EN];

  always_comb begin
    status_set = 8'h00;
    status_set[`CHT_BIT_SPG_FAIL]  = spg_fall;
    status_set[`CHT_BIT_ADC_DONE]  = adc_rise;
    status_set[`CHT_BIT_TEST_DONE] = finish;
    status_clr = wr_hit(`CHT_OFS_STATUS) ? bus.wdata : 8'h00;
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= 8'h00;
    end else begin
      status_q <= ((status_q & ~status_clr) | status_set) & `CHT_STATUS_USED;
    end
  end

  assign bus.alert = |(status_q & ~mask_q);

  // read data one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `CHT_OFS_CTRL:     bus.rdata <= ctrl_q;
        `CHT_OFS_STATUS:   bus.rdata <= status_q;
        `CHT_OFS_MASK:     bus.rdata <= mask_q;
        `CHT_OFS_THRESH:   bus.rdata <= thresh_q;
        `CHT_OFS_FINAL_HI: bus.rdata <= final_q[9:2];
        `CHT_OFS_FINAL_LO: bus.rdata <= {6'h00, final_q[1:0]};
        `CHT_OFS_INIT_HI:  bus.rdata <= init_q[9:2];
        `CHT_OFS_INIT_LO:  bus.rdata <= {6'h00, init_q[1:0]};
        `CHT_OFS_TIME_LO:  bus.rdata <= time_q[7:0];
        `CHT_OFS_TIME_HI:  bus.rdata <= time_q[15:8];
        `CHT_OFS_REG_CTRL: bus.rdata <= regc_q;
        default:           bus.rdata <= 8'h00;
      endcase
    end
  end
endmodule : cht_device

// ==== logic/cht_host.sv ====
// Purpose: host end that runs one cap health test through the register port
// Assumes: device answers reads one cycle after the strobe
// Notes:   start write keeps boost enable set
`timescale 1ns/1ns
`include "cht_params.svh"
module cht_host
  import cht_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  cht_if.host             bus,
  input  wire logic       start,
  input  wire logic       low_vin,
  input  wire logic [7:0] threshold,
  output logic            busy,
  output logic            done,
  output logic [9:0]      initial_voltage,
  output logic [9:0]      final_voltage,
  output logic [15:0]     discharge_time
);
  localparam logic [3:0] WAIT_STEP = 4'd4;
  localparam logic [3:0] LAST_STEP = 4'd14;

  // step table: {is_read, offset, data}
  function automatic logic [16:0] step_op(input logic [3:0] s, input logic [7:0] thr,
                                          input logic lv);
    unique case (s)
      4'd0:    step_op = {1'b0, `CHT_OFS_MASK, `CHT_HOST_MASK_SET};
      4'd1:    step_op = {1'b0, `CHT_OFS_THRESH, thr};
      4'd2:    step_op = {1'b0, `CHT_OFS_REG_CTRL, 6'h00, lv, 1'b0};
      4'd3:    step_op = {1'b0, `CHT_OFS_CTRL, `CHT_HOST_START};
      4'd5:    step_op = {1'b1, `CHT_OFS_STATUS, 8'h00};
      4'd6:    step_op = {1'b1, `CHT_OFS_FINAL_HI, 8'h00};
      4'd7:    step_op = {1'b1, `CHT_OFS_FINAL_LO, 8'h00};
      4'd8:    step_op = {1'b1, `CHT_OFS_INIT_HI, 8'h00};
      4'd9:    step_op = {1'b1, `CHT_OFS_INIT_LO, 8'h00};
      4'd10:   step_op = {1'b1, `CHT_OFS_TIME_LO, 8'h00};
      4'd11:   step_op = {1'b1, `CHT_OFS_TIME_HI, 8'h00};
      4'd12:   step_op = {1'b0, `CHT_OFS_STATUS, 8'h80};
      4'd13:   step_op = {1'b0, `CHT_OFS_MASK, 8'h00};
      4'd14:   step_op = {1'b0, `CHT_OFS_REG_CTRL, 8'h00};
      default: step_op = 17'h00000;
    endcase
  endfunction : step_op

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  cht_hstate_t state_q;
  logic [3:0]  step_q;
  logic [16:0] op;
  logic        rd_q;
  logic [7:0]  rd_addr_q;

  assign op = step_op(step_q, threshold, low_vin);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= CHT_H_IDLE;
      step_q  <= 4'd0;
    end else begin
      unique case (state_q)
        CHT_H_IDLE: if (start) begin
          state_q <= CHT_H_RUN;
          step_q  <= 4'd0;
        end
        CHT_H_RUN: begin
          if (step_q == LAST_STEP) state_q <= CHT_H_IDLE;
          else if (step_q + 4'd1 == WAIT_STEP) state_q <= CHT_H_WAIT;
          step_q <= step_q + 4'd1;
        end
        CHT_H_WAIT: if (bus.alert) begin
          state_q <= CHT_H_RUN;
          step_q  <= step_q + 4'd1;
        end
        default: state_q <= CHT_H_IDLE;
      endcase
    end
  end

  // strobes come from flops so they change just after the edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 8'h00;
      bus.wdata <= 8'h00;
    end else begin
      bus.wr    <= (state_q == CHT_H_RUN) && !op[16];
      bus.rd    <= (state_q == CHT_H_RUN) && op[16];
      bus.addr  <= op[15:8];
      bus.wdata <= op[7:0];
    end
  end

  // ---------------------------------------------------------------
  // read capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q      <= 1'b0;
      rd_addr_q <= 8'h00;
    end else begin
      rd_q      <= bus.rd;
      rd_addr_q <= bus.addr;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      initial_voltage <= 10'h000;
      final_voltage   <= 10'h000;
      discharge_time  <= 16'h0000;
    end else if (rd_q) begin
      unique case (rd_addr_q)
        `CHT_OFS_FINAL_HI: final_voltage[9:2]   <= bus.rdata;
        `CHT_OFS_FINAL_LO: final_voltage[1:0]   <= bus.rdata[1:0];
        `CHT_OFS_INIT_HI:  initial_voltage[9:2] <= bus.rdata;
        `CHT_OFS_INIT_LO:  initial_voltage[1:0] <= bus.rdata[1:0];
        `CHT_OFS_TIME_LO:  discharge_time[7:0]  <= bus.rdata;
        `CHT_OFS_TIME_HI:  discharge_time[15:8] <= bus.rdata;
        default:           discharge_time       <= discharge_time;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      done <= 1'b0;
    end else begin
      done <= (state_q == CHT_H_RUN) && (step_q == LAST_STEP);
    end
  end

  assign busy = (state_q != CHT_H_IDLE);
endmodule : cht_host

// ==== verif/cht_assertions.sv ====
// Purpose: checks on the host-device register port of the cap health test
// Assumes: one clock, the host end is the only bus master
// Notes:   sees the interface signals only, so device pins are judged by the bench
`timescale 1ns/1ns
`include "cht_params.svh"
module cht_assertions (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       alert
);
  // ---------------------------------------------------------------
  // host progress flags
  // ---------------------------------------------------------------
  logic mask_q;
  logic setup_q;
  logic started_q;
  logic go;
  assign go = wr && addr == `CHT_OFS_CTRL && wdata[`CHT_BIT_TEST_REQ];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= 1'b0;
    end else if (wr && addr == `CHT_OFS_MASK) begin
      mask_q <= wdata[`CHT_BIT_SPG_FAIL] && wdata[`CHT_BIT_ADC_DONE];
    end
  end

  // threshold write seen; never cleared, so only the first setup is judged
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      setup_q <= 1'b0;
    end else if (wr && addr == `CHT_OFS_THRESH) begin
      setup_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      started_q <= 1'b0;
    end else if (go) begin
      started_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_START_MASKED: assert property (go |-> mask_q)
    else $error("test started with events unmasked");
  AST_START_THRESH: assert property (go |-> setup_q)
    else $error("test started before threshold write");
  AST_START_BOOST: assert property (go |-> wdata[`CHT_BIT_BOOST_EN])
    else $error("start write dropped boost enable");
  AST_CLEAR_ALERT: assert property (wr && addr == `CHT_OFS_STATUS && wdata[7] && mask_q
    |=> !alert) else $error("alert stayed after done clear");
  AST_ALERT_HOLDS: assert property (alert && !(wr && (addr == `CHT_OFS_STATUS
    || addr == `CHT_OFS_MASK)) |=> alert) else $error("alert fell without clear");
  AST_ALERT_CAUSE: assert property ($rose(alert) |-> started_q)
    else $error("alert before any test");
  AST_HOST_READS: assert property ($rose(alert) && mask_q
    |-> ##[1:8] (rd && addr == `CHT_OFS_STATUS)) else $error("status not read");
  AST_LOW_BITS: assert property (rd && (addr == `CHT_OFS_FINAL_LO
    || addr == `CHT_OFS_INIT_LO) |=> rdata[7:2] == 6'h00) else $error("low reg upper bits");
  AST_TIME_PAIR: assert property (rd && addr == `CHT_OFS_TIME_LO
    |=> rd && addr == `CHT_OFS_TIME_HI) else $error("time bytes split");

  COV_START: cover property (go);
  COV_ALERT: cover property ($rose(alert));
  COV_CLEAR: cover property (wr && addr == `CHT_OFS_STATUS && wdata[7]);
endmodule : cht_assertions

// ==== verif/test_storage_cap_health_test.sv ====
// Purpose: self-checking bench joining the host and device ends
// Assumes: ms counter shortened to 20 cycles
// Notes:   bench plays the analog pins and the converter
`timescale 1ns/1ns
`include "cht_params.svh"
module test_storage_cap_health_test;
  import cht_pkg::*;
  localparam int MS    = 20;
  localparam int LIMIT = 3000;
  logic        core_clk  = 1'b0;
  logic        rstn      = 1'b0;
  logic        start     = 1'b0;
  logic        low_vin   = 1'b0;
  cht_byte_t   threshold = 8'h00;
  logic        charged   = 1'b0;
  logic        at_ref    = 1'b0;
  logic        pgood     = 1'b1;
  logic        pwr_fail  = 1'b0;
  logic        depleted  = 1'b0;
  logic        adc_done  = 1'b0;
  logic [9:0]  adc_data  = 10'h000;
  logic        busy, done, adc_start, boost_on, disch_on, buck, reg_en;
  logic [9:0]  v_init, v_fin;
  logic [15:0] d_time;
  cht_byte_t   thr_out;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  cht_if u_cht_if ();
  cht_host u_cht_host (.core_clk(core_clk), .rstn(rstn), .bus(u_cht_if.host), .start(start),
    .low_vin(low_vin), .threshold(threshold), .busy(busy), .done(done),
    .initial_voltage(v_init), .final_voltage(v_fin), .discharge_time(d_time));
  cht_device #(.MS_CYCLES(MS)) u_cht_device (.core_clk(core_clk), .rstn(rstn),
    .bus(u_cht_if.dev), .storage_charged_pin(charged), .storage_feedback_at_ref_pin(at_ref),
    .storage_power_good_pin(pgood), .input_power_fail_pin(pwr_fail),
    .storage_depleted_pin(depleted), .adc_done_pin(adc_done), .adc_data(adc_data),
    .adc_start(adc_start), .boost_switch_en(boost_on), .discharge_switch_on(disch_on),
    .buck_release(buck), .storage_to_core_regulator_enable(reg_en),
    .storage_good_threshold(thr_out));
  cht_assertions u_cht_assertions (.core_clk(core_clk), .rstn(rstn), .addr(u_cht_if.addr),
    .wdata(u_cht_if.wdata), .wr(u_cht_if.wr), .rd(u_cht_if.rd), .rdata(u_cht_if.rdata),
    .alert(u_cht_if.alert));

  always #25 core_clk = ~core_clk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic chk_val(input logic [15:0] act, input logic [15:0] exp);
    comparisons++;
    if (act !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, act, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic act, input logic exp);
    chk_val({15'h0000, act}, {15'h0000, exp});
  endtask : chk_bit

  // ---------------------------------------------------------------
  // one full test; n cycles from feedback crossing to power-good fall
  // ---------------------------------------------------------------
  task automatic run_test(input logic lv, input cht_byte_t thr, input logic [9:0] v0,
                          input logic [9:0] v1, input int n, input logic [15:0] t);
    int i;
    @(posedge core_clk);
    low_vin   <= lv;
    threshold <= thr;
    start     <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (12) @(posedge core_clk);
    #1;
    chk_bit(disch_on, 1'b0);
    chk_bit(boost_on, 1'b1);
    chk_val({8'h00, thr_out}, {8'h00, thr});
    chk_bit(reg_en, lv);
    @(posedge core_clk);
    charged <= 1'b1;
    for (i = 0; i < 20 && disch_on !== 1'b1; i++) begin @(posedge core_clk); #1; end
    chk_bit(disch_on, 1'b1);
    chk_bit(boost_on, 1'b0);
    @(posedge core_clk);
    at_ref <= 1'b1;
    for (i = 0; i < 20 && adc_start !== 1'b1; i++) begin @(posedge core_clk); #1; end
    chk_bit(adc_start, 1'b1);
    @(posedge core_clk);
    adc_data <= v0;
    adc_done <= 1'b1;
    repeat (3) @(posedge core_clk);
    adc_done <= 1'b0;
    repeat (n - i - 4) @(posedge core_clk);
    pgood <= 1'b0;
    for (i = 0; i < 20 && adc_start !== 1'b1; i++) begin @(posedge core_clk); #1; end
    chk_bit(adc_start, 1'b1);
    chk_bit(disch_on, 1'b0);
    @(posedge core_clk);
    adc_data <= v1;
    adc_done <= 1'b1;
    repeat (3) @(posedge core_clk);
    adc_done <= 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) begin @(posedge core_clk); #1; end
    chk_bit(done, 1'b1);
    chk_val({6'h00, v_init}, {6'h00, v0});
    chk_val({6'h00, v_fin}, {6'h00, v1});
    chk_val(d_time, t);
    chk_bit(boost_on, 1'b1);
    chk_bit(u_cht_if.alert, 1'b1);
    @(posedge core_clk);
    charged <= 1'b0;
    at_ref  <= 1'b0;
    pgood   <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : run_test

  task automatic test_reset;
    #1;
    chk_bit(boost_on, 1'b1);
    chk_bit(disch_on, 1'b0);
    chk_bit(u_cht_if.alert, 1'b0);
    chk_bit(busy, 1'b0);
    $display("test_reset finished");
  endtask : test_reset

  task automatic test_first_run;
    run_test(1'b1, 8'h00, 10'h2a7, 10'h135, 3 * MS + 10, 16'h0003);
    $display("test_first_run finished");
  endtask : test_first_run

  // stale count from the first run would show as 4
  task automatic test_second_run;
    run_test(1'b0, 8'h3c, 10'h3ff, 10'h001, MS + 10, 16'h0001);
    $display("test_second_run finished");
  endtask : test_second_run

  // host is left waiting, so this runs last
  task automatic test_buck_abort;
    int i;
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (12) @(posedge core_clk);
    charged <= 1'b1;
    for (i = 0; i < 20 && disch_on !== 1'b1; i++) begin @(posedge core_clk); #1; end
    @(posedge core_clk);
    pwr_fail <= 1'b1;
    for (i = 0; i < 20 && buck !== 1'b1; i++) begin @(posedge core_clk); #1; end
    chk_bit(buck, 1'b1);
    chk_bit(disch_on, 1'b0);
    @(posedge core_clk);
    at_ref <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    chk_bit(disch_on, 1'b0);
    chk_bit(u_cht_if.alert, 1'b0);
    @(posedge core_clk);
    pwr_fail <= 1'b0;
    depleted <= 1'b1;
    for (i = 0; i < 20 && buck !== 1'b0; i++) begin @(posedge core_clk); #1; end
    chk_bit(buck, 1'b0);
    $display("test_buck_abort finished");
  endtask : test_buck_abort

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    test_reset();
    test_first_run();
    test_second_run();
    test_buck_abort();
    give_verdict();
  end
endmodule : test_storage_cap_health_test
